// [verilog/buck_sleep_consts.svh]
// Offsets, field positions, reset values for the buck sleep register bank
// Assumes inclusion by bare name from the pin synchroniser and the top module
`ifndef BUCK_SLEEP_CONSTS_SVH
`define BUCK_SLEEP_CONSTS_SVH

`define RAIL1_SLEEP_CONTROL_OFFSET 8'h92
`define RAIL2_SLEEP_CONTROL_OFFSET 8'h93
`define RAIL4_NORMAL_VOLTAGE_OFFSET 8'h94
`define RAIL4_SLEEP_VOLTAGE_OFFSET 8'h95

`define CODE_MSB 7
`define CODE_LSB 1
`define FLAG_BIT 0
`define CODE_WIDTH 7
`define REG_WIDTH 8

// Factory values are not known here; neutral defaults
`define RAIL1_SLEEP_CONTROL_RESET 8'h00
`define RAIL2_SLEEP_CONTROL_RESET 8'h00
`define RAIL4_NORMAL_VOLTAGE_RESET 8'h00
`define RAIL4_SLEEP_VOLTAGE_RESET 8'h00
`define UNMAPPED_READ_VALUE 8'h00

`define SYNC_STAGES 3

`endif

// [verilog/buck_sleep_pkg.sv]
// Types shared by the buck sleep register bank
// Assumes the constants header is on the include path
package buck_sleep_pkg;
  typedef enum logic [1:0] {
    CFG_RESET = 2'b00,
    CFG_CAPTURE = 2'b01,
    CFG_RUN = 2'b10
  } cfg_state_t;

  typedef enum logic {
    PIN_A = 1'b0,
    PIN_B = 1'b1
  } pin_sel_t;
endpackage

// [verilog/sleep_pin_sync.sv]
// Three-stage synchroniser with agreement filter for the sleep pins
// Assumes pins are asynchronous to sys_clk; resets to the inactive (high) level
`timescale 1ns/10ps
`include "buck_sleep_consts.svh"
module sleep_pin_sync #(
  parameter int WIDTH = 2
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] pin_raw,
  output logic [WIDTH-1:0] pin_clean
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_pin
      logic [`SYNC_STAGES-1:0] stage;
      wire agree;
      // Stage 0 feeds only stage 1
      assign agree = (stage[1] == stage[2]);
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          stage <= 3'b111;
        end else begin
          stage <= {stage[1:0], pin_raw[i]};
        end
      end
      // Level counts only once stages two and three agree
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          pin_clean[i] <= 1'b1;
        end else if (agree) begin
          pin_clean[i] <= stage[2];
        end
      end
    end
  endgenerate
endmodule

// [verilog/buck_sleep_voltage_select_regs.sv]
// Sleep and normal voltage code registers for three buck rails
// Assumes the serial control block presents one-cycle register strobes on
// sys_clk, and that rail normal codes for rails 1 and 2 come from elsewhere.
//
// Overview of operation
// - Rail 1 sleep voltage code is bits 7:1 of its sleep control register.
// - Rail 1 sleep-enable low: always apply rail 1 normal code.
// - Rail 1 sleep-enable high: sleep code while assigned pin low, else normal.
// - Rail 1 sleep pin is pin A or B, fixed by factory setting.
// - Rail 2 sleep voltage code is bits 7:1 of its sleep control register.
// - Rail 2 sleep-enable low: always apply rail 2 normal code.
// - Rail 2 sleep-enable high: sleep code while assigned pin low, else normal.
// - Rail 2 sleep pin chosen by factory from the same two pins.
// - Rail 4 normal voltage code is bits 7:1 of its voltage register.
// - Rail 4 decay bit low: lower new code reached by active slewing.
// - Rail 4 decay bit high: lower new code reached by passive decay.
// - Rail 4 keeps a separate 7-bit sleep code in its own register.
`timescale 1ns/10ps
`include "buck_sleep_consts.svh"
module buck_sleep_voltage_select_regs
  import buck_sleep_pkg::*;
#(
  parameter logic [7:0] RAIL1_CTRL_INIT = `RAIL1_SLEEP_CONTROL_RESET,
  parameter logic [7:0] RAIL2_CTRL_INIT = `RAIL2_SLEEP_CONTROL_RESET,
  parameter logic [7:0] RAIL4_VOLT_INIT = `RAIL4_NORMAL_VOLTAGE_RESET,
  parameter logic [7:0] RAIL4_SLEEP_INIT = `RAIL4_SLEEP_VOLTAGE_RESET
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_wr_data,
  output logic [7:0] reg_rd_data,
  output logic reg_rd_valid,
  input wire logic sleep_pin_a_n,
  input wire logic sleep_pin_b_n,
  input wire logic rail1_factory_pin_select,
  input wire logic rail2_factory_pin_select,
  input wire logic [6:0] rail1_normal_voltage_code,
  input wire logic [6:0] rail2_normal_voltage_code,
  output logic [6:0] rail1_setpoint,
  output logic [6:0] rail2_setpoint,
  output logic rail1_in_sleep,
  output logic rail2_in_sleep,
  output logic [6:0] rail4_setpoint,
  output logic [6:0] rail4_sleep_voltage_code,
  output logic rail4_active_slew_down,
  output logic rail4_passive_decay_down
);

  // Register storage
  logic [7:0] rail1_sleep_control;
  logic [7:0] rail2_sleep_control;
  logic [7:0] rail4_normal_voltage;
  logic [7:0] rail4_sleep_voltage;

  // Factory pin assignment, caught after reset release
  cfg_state_t cfg_state;
  cfg_state_t next_cfg_state;
  pin_sel_t rail1_pin;
  pin_sel_t rail2_pin;

  logic [1:0] pins_clean;

  // Pick the selected pin and report whether the rail sits at its sleep code
  function automatic logic sleep_selected(input logic enable, input pin_sel_t sel,
                                          input logic [1:0] pins);
    logic pin_level;
    pin_level = (sel == PIN_B) ? pins[1] : pins[0];
    sleep_selected = enable & ~pin_level;
  endfunction

  // Address decode
  wire hit_rail1 = (reg_addr == `RAIL1_SLEEP_CONTROL_OFFSET);
  wire hit_rail2 = (reg_addr == `RAIL2_SLEEP_CONTROL_OFFSET);
  wire hit_rail4_volt = (reg_addr == `RAIL4_NORMAL_VOLTAGE_OFFSET);
  wire hit_rail4_sleep = (reg_addr == `RAIL4_SLEEP_VOLTAGE_OFFSET);

  wire wr_rail1 = reg_wr_en & hit_rail1;
  wire wr_rail2 = reg_wr_en & hit_rail2;
  wire wr_rail4_volt = reg_wr_en & hit_rail4_volt;
  wire wr_rail4_sleep = reg_wr_en & hit_rail4_sleep;

  // Fields
  wire [6:0] rail1_sleep_voltage_code = rail1_sleep_control[`CODE_MSB:`CODE_LSB];
  wire rail1_sleep_select_enable = rail1_sleep_control[`FLAG_BIT];
  wire [6:0] rail2_sleep_voltage_code = rail2_sleep_control[`CODE_MSB:`CODE_LSB];
  wire rail2_sleep_select_enable = rail2_sleep_control[`FLAG_BIT];
  wire [6:0] rail4_normal_voltage_code = rail4_normal_voltage[`CODE_MSB:`CODE_LSB];
  wire rail4_passive_ramp_down_select = rail4_normal_voltage[`FLAG_BIT];
  wire [6:0] new_rail4_code = reg_wr_data[`CODE_MSB:`CODE_LSB];
  wire new_rail4_decay = reg_wr_data[`FLAG_BIT];
  wire rail4_going_down = wr_rail4_volt & (new_rail4_code < rail4_normal_voltage_code);

  // Pin choice not valid until the factory setting is captured
  wire cfg_ready = (cfg_state == CFG_RUN);

  // Sleep selection, held at normal until configuration is known
  wire rail1_sleep_sel = cfg_ready &
    sleep_selected(rail1_sleep_select_enable, rail1_pin, pins_clean);
  wire rail2_sleep_sel = cfg_ready &
    sleep_selected(rail2_sleep_select_enable, rail2_pin, pins_clean);

  wire [6:0] next_rail1_setpoint =
    rail1_sleep_sel ? rail1_sleep_voltage_code : rail1_normal_voltage_code;
  wire [6:0] next_rail2_setpoint =
    rail2_sleep_sel ? rail2_sleep_voltage_code : rail2_normal_voltage_code;

  // Read mux; unmapped offsets read as a fixed value
  wire [7:0] next_rd_data =
    hit_rail1 ? rail1_sleep_control :
    hit_rail2 ? rail2_sleep_control :
    hit_rail4_volt ? rail4_normal_voltage :
    hit_rail4_sleep ? {rail4_sleep_voltage[7:1], 1'b0} :
    `UNMAPPED_READ_VALUE;

  sleep_pin_sync #(
    .WIDTH(2)
  ) u_pin_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pin_raw({sleep_pin_b_n, sleep_pin_a_n}),
    .pin_clean(pins_clean)
  );

  // Configuration sequencer
  always_comb begin
    next_cfg_state = cfg_state;
    unique case (cfg_state)
      CFG_RESET: next_cfg_state = CFG_CAPTURE;
      CFG_CAPTURE: next_cfg_state = CFG_RUN;
      CFG_RUN: next_cfg_state = CFG_RUN;
      default: next_cfg_state = CFG_RESET;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_state <= CFG_RESET;
    end else begin
      cfg_state <= next_cfg_state;
    end
  end

  // Straps are sampled by the clock, never by the reset itself
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rail1_pin <= PIN_A;
      rail2_pin <= PIN_A;
    end else if (cfg_state == CFG_CAPTURE) begin
      rail1_pin <= pin_sel_t'(rail1_factory_pin_select);
      rail2_pin <= pin_sel_t'(rail2_factory_pin_select);
    end
  end

  // Register writes
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rail1_sleep_control <= RAIL1_CTRL_INIT;
    end else if (wr_rail1) begin
      rail1_sleep_control <= reg_wr_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rail2_sleep_control <= RAIL2_CTRL_INIT;
    end else if (wr_rail2) begin
      rail2_sleep_control <= reg_wr_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rail4_normal_voltage <= RAIL4_VOLT_INIT;
    end else if (wr_rail4_volt) begin
      rail4_normal_voltage <= reg_wr_data;
    end
  end

  // Bit 0 is reserved and always stored as zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rail4_sleep_voltage <= {RAIL4_SLEEP_INIT[7:1], 1'b0};
    end else if (wr_rail4_sleep) begin
      rail4_sleep_voltage <= {reg_wr_data[7:1], 1'b0};
    end
  end

  // Read port, one cycle after the strobe
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rd_data <= 8'h00;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en) begin
        reg_rd_data <= next_rd_data;
      end
    end
  end

  // Registered setpoints so the regulator sees one clean edge per change
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rail1_setpoint <= 7'h00;
      rail2_setpoint <= 7'h00;
      rail1_in_sleep <= 1'b0;
      rail2_in_sleep <= 1'b0;
    end else begin
      rail1_setpoint <= next_rail1_setpoint;
      rail2_setpoint <= next_rail2_setpoint;
      rail1_in_sleep <= rail1_sleep_sel;
      rail2_in_sleep <= rail2_sleep_sel;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rail4_setpoint <= 7'h00;
      rail4_sleep_voltage_code <= 7'h00;
    end else begin
      rail4_setpoint <= rail4_normal_voltage_code;
      rail4_sleep_voltage_code <= rail4_sleep_voltage[`CODE_MSB:`CODE_LSB];
    end
  end

  // Down-transition mode holds until the next write to the rail 4 voltage
  // register; nothing ends it when the rail settles, only a later write does.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rail4_active_slew_down <= 1'b0;
      rail4_passive_decay_down <= 1'b0;
    end else if (wr_rail4_volt) begin
      rail4_active_slew_down <= rail4_going_down & ~new_rail4_decay;
      rail4_passive_decay_down <= rail4_going_down & new_rail4_decay;
    end
  end

  // Stored decay choice is the bit that the write just placed
  wire unused_decay = rail4_passive_ramp_down_select;

endmodule

// [sim/buck_sleep_checker_asserts.sv]
// Assertions on the ports of the buck sleep register bank
// Assumes binding to the top module, straps held steady while running,
// and default parameters, so the rail 4 voltage register resets to zero
`timescale 1ns/10ps
module buck_sleep_checker (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_wr_data,
  input wire logic [7:0] reg_rd_data,
  input wire logic reg_rd_valid,
  input wire logic sleep_pin_a_n,
  input wire logic sleep_pin_b_n,
  input wire logic rail1_factory_pin_select,
  input wire logic rail2_factory_pin_select,
  input wire logic [6:0] rail1_normal_voltage_code,
  input wire logic [6:0] rail2_normal_voltage_code,
  input wire logic [6:0] rail1_setpoint,
  input wire logic [6:0] rail2_setpoint,
  input wire logic rail1_in_sleep,
  input wire logic rail2_in_sleep,
  input wire logic [6:0] rail4_setpoint,
  input wire logic [6:0] rail4_sleep_voltage_code,
  input wire logic rail4_active_slew_down,
  input wire logic rail4_passive_decay_down
);
  wire pin1 = rail1_factory_pin_select ? sleep_pin_b_n : sleep_pin_a_n;
  wire pin2 = rail2_factory_pin_select ? sleep_pin_b_n : sleep_pin_a_n;
  wire wr94 = reg_wr_en && reg_addr == 8'h94;
  wire wr95 = reg_wr_en && reg_addr == 8'h95;
  logic [6:0] last_rail4_code;
  // Last written code; the setpoint port lags the register too far to compare
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      last_rail4_code <= 7'h00;
    end else if (wr94) begin
      last_rail4_code <= reg_wr_data[7:1];
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  rd_valid_next_a: assert property (reg_rd_en |=> reg_rd_valid)
    else $error("read valid missing");
  rd_valid_pulse_a: assert property (!reg_rd_en |=> !reg_rd_valid)
    else $error("read valid stray");
  rd_data_hold_a: assert property (!reg_rd_en |=> $stable(reg_rd_data))
    else $error("read data moved");
  rail4_code_a: assert property (wr94 |-> ##2 rail4_setpoint == $past(reg_wr_data[7:1], 2))
    else $error("rail4 code wrong");
  rail4_sleep_a: assert property (wr95 |-> ##2
    rail4_sleep_voltage_code == $past(reg_wr_data[7:1], 2))
    else $error("rail4 sleep code wrong");
  slew_mode_a: assert property (wr94 |=> rail4_active_slew_down ==
    ($past(reg_wr_data[7:1]) < $past(last_rail4_code) && !$past(reg_wr_data[0])))
    else $error("slew flag wrong");
  decay_mode_a: assert property (wr94 |=> rail4_passive_decay_down ==
    ($past(reg_wr_data[7:1]) < $past(last_rail4_code) && $past(reg_wr_data[0])))
    else $error("decay flag wrong");
  awake_one_a: assert property (pin1 [*8] |-> !rail1_in_sleep)
    else $error("rail1 asleep with pin high");
  awake_two_a: assert property (pin2 [*8] |-> !rail2_in_sleep)
    else $error("rail2 asleep with pin high");
  normal_one_a: assert property ($past(rst_n) && !rail1_in_sleep
    |-> rail1_setpoint == $past(rail1_normal_voltage_code)) else $error("rail1 not normal");
  cover property (rail1_in_sleep);
  cover property (rail2_in_sleep);
  cover property (rail4_passive_decay_down);
endmodule
bind buck_sleep_voltage_select_regs buck_sleep_checker u_buck_sleep_checker (.*);

// [sim/host_pin_model.sv]
// Host side model driving the two active-low sleep pins
// Assumes the bench asks for sleep per pin; bit 0 is pin A
`timescale 1ns/10ps
module host_pin_model (
  input wire logic sys_clk,
  input wire logic [1:0] want_sleep,
  output logic sleep_pin_a_n,
  output logic sleep_pin_b_n
);
  initial {sleep_pin_b_n, sleep_pin_a_n} = 2'h3;
  // Moves off the edge, so the sync chain sees an asynchronous change
  always @(posedge sys_clk) {sleep_pin_b_n, sleep_pin_a_n} <= #1 ~want_sleep;
endmodule

// [sim/buck_sleep_voltage_select_regs_bench.sv]
// Self-checking bench for the buck sleep register bank
// Assumes default parameters, so every register resets to 8'h00
`timescale 1ns/10ps
module buck_sleep_voltage_select_regs_bench;
  logic sys_clk = 1'h0, rst_n = 1'h0, reg_wr_en = 1'h0, reg_rd_en = 1'h0, reg_rd_valid;
  logic [7:0] reg_addr = 8'h00, reg_wr_data = 8'h00, reg_rd_data;
  logic sleep_pin_a_n, sleep_pin_b_n, rail1_in_sleep, rail2_in_sleep;
  logic rail1_factory_pin_select = 1'h0, rail2_factory_pin_select = 1'h1;
  logic rail4_active_slew_down, rail4_passive_decay_down;
  logic [6:0] rail1_normal_voltage_code = 7'h11, rail2_normal_voltage_code = 7'h22;
  logic [6:0] rail1_setpoint, rail2_setpoint, rail4_setpoint, rail4_sleep_voltage_code;
  logic [1:0] want_sleep = 2'h0;
  int num_errors = 0, check_count = 0, cycles = 0;
  always #10 sys_clk = ~sys_clk;
  host_pin_model u_host_pin_model (.sys_clk, .want_sleep, .sleep_pin_a_n, .sleep_pin_b_n);
  buck_sleep_voltage_select_regs u_buck_sleep_voltage_select_regs (.*);
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk) #1;
    reg_addr = a;
    reg_wr_data = d;
    reg_wr_en = 1'h1;
    @(posedge sys_clk) #1;
    reg_wr_en = 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk) #1;
    reg_addr = a;
    reg_rd_en = 1'h1;
    @(posedge sys_clk) #1;
    reg_rd_en = 1'h0;
    check({7'h00, reg_rd_valid}, 8'h01, "valid");
    check(reg_rd_data, exp, "read");
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Hang guard, far above the fewer than one hundred cycles the tests need
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      $display("MISMATCH t=%0t timeout", $time);
      complete_run();
    end
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    #1 rst_n = 1'h1;
    for (int a = 8'h91; a < 8'h97; a++) rd(a[7:0], 8'h00);
    $display("test reset values done");
    wr(8'h92, 8'hA5);
    wr(8'h93, 8'h5A);
    wr(8'h95, 8'hFF);
    rd(8'h92, 8'hA5);
    rd(8'h93, 8'h5A);
    rd(8'h95, 8'hFE);
    check({1'h0, rail4_sleep_voltage_code}, 8'h7F, "r4 sleep");
    $display("test readback done");
    wr(8'h94, 8'h80);
    wr(8'h94, 8'h40);
    settle(1);
    check({1'h0, rail4_setpoint}, 8'h20, "r4 code");
    check({6'h00, rail4_active_slew_down, rail4_passive_decay_down}, 8'h02, "slew");
    wr(8'h94, 8'h11);
    settle(1);
    check({6'h00, rail4_active_slew_down, rail4_passive_decay_down}, 8'h01, "decay");
    wr(8'h94, 8'h41);
    settle(1);
    check({6'h00, rail4_active_slew_down, rail4_passive_decay_down}, 8'h00, "up");
    $display("test rail4 done");
    want_sleep = 2'h3;
    settle(2);
    check({1'h0, rail1_setpoint}, 8'h11, "sync");
    settle(7);
    check({1'h0, rail1_setpoint}, 8'h52, "r1 sleep");
    check({1'h0, rail2_setpoint}, 8'h22, "r2 off");
    check({6'h00, rail1_in_sleep, rail2_in_sleep}, 8'h02, "flags");
    wr(8'h93, 8'h5B);
    settle(3);
    check({1'h0, rail2_setpoint}, 8'h2D, "r2 sleep");
    check({6'h00, rail1_in_sleep, rail2_in_sleep}, 8'h03, "flags both");
    want_sleep = 2'h1;
    settle(9);
    check({1'h0, rail2_setpoint}, 8'h22, "r2 wake");
    check({6'h00, rail1_in_sleep, rail2_in_sleep}, 8'h02, "flags wake");
    check({1'h0, rail1_setpoint}, 8'h52, "r1 pin");
    wr(8'h92, 8'hA4);
    settle(3);
    check({1'h0, rail1_setpoint}, 8'h11, "r1 off");
    $display("test sleep select done");
    complete_run();
  end
endmodule
